/* logic/fpes_engine.v */
`timescale 1ns/1ps
`include "fpes_map.vh"
module fpes_engine #(
	parameter [15:0] T_PAGE = `FPES_T_PAGE,
	parameter [15:0] T_MASS = `FPES_T_MASS
) (
	input wire pclk,
	input wire presetn,
	input wire start,
	input wire [7:0] cmd,
	input wire [15:0] addr,
	input wire [7:0] data,
	input wire [7:0] div,
	output reg busy_r,
	output reg done_r,
	output reg flash_prog_r,
	output reg flash_erase_r,
	output reg flash_mass_r,
	output reg flash_blank_r,
	output reg [15:0] flash_addr_r,
	output reg [7:0] flash_data_r
);
	reg [8:0] pcnt_r;
	reg [15:0] tcnt_r;
	wire [8:0] reload;
	wire tick;

	function [15:0] op_len;
		input [7:0] c;
		begin
			case (c)
				`FPES_CMD_BYTE: op_len = `FPES_T_BYTE;
				`FPES_CMD_BURST: op_len = `FPES_T_BURST;
				`FPES_CMD_PAGE: op_len = T_PAGE;
				`FPES_CMD_MASS: op_len = T_MASS;
				default: op_len = `FPES_T_BLANK;
			endcase
		end
	endfunction

	// one flash tick every (div[5:0]+1) bus cycles, times eight with the prescaler
	assign reload = div[`FPES_DIV_PRE8] ? {div[5:0], 3'b111} : {3'b000, div[5:0]};
	assign tick = (pcnt_r == 9'h000);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_r <= 1'b0;
			done_r <= 1'b0;
			pcnt_r <= 9'h000;
			tcnt_r <= 16'h0000;
			flash_prog_r <= 1'b0;
			flash_erase_r <= 1'b0;
			flash_mass_r <= 1'b0;
			flash_blank_r <= 1'b0;
			flash_addr_r <= 16'h0000;
			flash_data_r <= 8'h00;
		end else begin
			done_r <= 1'b0;
			if (start && !busy_r) begin
				busy_r <= 1'b1;
				pcnt_r <= reload;
				tcnt_r <= op_len(cmd);
				flash_prog_r <= (cmd == `FPES_CMD_BYTE) || (cmd == `FPES_CMD_BURST);
				flash_erase_r <= (cmd == `FPES_CMD_PAGE) || (cmd == `FPES_CMD_MASS);
				flash_mass_r <= (cmd == `FPES_CMD_MASS);
				flash_blank_r <= (cmd == `FPES_CMD_BLANK);
				if (cmd == `FPES_CMD_PAGE)
					flash_addr_r <= addr & `FPES_PAGE_MASK;
				else
					flash_addr_r <= addr;
				// erase and blank check never present the captured data
				if ((cmd == `FPES_CMD_BYTE) || (cmd == `FPES_CMD_BURST))
					flash_data_r <= data;
				else
					flash_data_r <= 8'h00;
			end else if (busy_r) begin
				if (tick) begin
					pcnt_r <= reload;
					if (tcnt_r <= 16'h0001) begin
						busy_r <= 1'b0;
						done_r <= 1'b1;
						flash_prog_r <= 1'b0;
						flash_erase_r <= 1'b0;
						flash_mass_r <= 1'b0;
						flash_blank_r <= 1'b0;
					end else begin
						tcnt_r <= tcnt_r - 16'h0001;
					end
				end else begin
					pcnt_r <= pcnt_r - 9'h001;
				end
			end
		end
	end
endmodule // fpes_engine

/* logic/fpes_map.vh */
`ifndef FPES_MAP_VH
`define FPES_MAP_VH
// register byte offsets
`define FPES_OFS_CLKDIV 32'h0000_0000
`define FPES_OFS_CMD 32'h0000_0004
`define FPES_OFS_STAT 32'h0000_0008
`define FPES_OFS_INTST 32'h0000_000C
`define FPES_OFS_INTMSK 32'h0000_0010
`define FPES_OFS_CAPADDR 32'h0000_0014
`define FPES_OFS_CAPDATA 32'h0000_0018
// flash array window: paddr[31:16] selects, paddr[15:0] is the array address
`define FPES_ARRAY_HI 16'h0001
// status register bit positions
`define FPES_ST_CBEF 7
`define FPES_ST_CCF 6
`define FPES_ST_ACCERR 5
// clock divider fields
`define FPES_DIV_LOADED 7
`define FPES_DIV_PRE8 6
// interrupt status / mask bit positions
`define FPES_IRQ_DONE 0
`define FPES_IRQ_ERR 1
// command codes
`define FPES_CMD_BLANK 8'h05
`define FPES_CMD_BYTE 8'h20
`define FPES_CMD_BURST 8'h25
`define FPES_CMD_PAGE 8'h40
`define FPES_CMD_MASS 8'h41
// page of 512 bytes: low nine address bits are dropped for page erase
`define FPES_PAGE_MASK 16'hFE00
// array regions shadowed by ram and by the high page registers
`define FPES_RAM_LO 16'h0000
`define FPES_RAM_HI 16'h086F
`define FPES_HPR_LO 16'h1800
`define FPES_HPR_HI 16'h184F
// reset values
`define FPES_RST_DIV 8'h00
`define FPES_RST_MASK 2'h0
// operation lengths in divided flash clock ticks
`define FPES_T_BYTE 16'h0009
`define FPES_T_BURST 16'h0004
`define FPES_T_BLANK 16'h0010
`define FPES_T_PAGE 16'h0FA0
`define FPES_T_MASS 16'h4E20
`endif

/* logic/fpes_sequencer.v */
`timescale 1ns/1ps
`include "fpes_map.vh"
module fpes_sequencer #(
	parameter [15:0] T_PAGE = `FPES_T_PAGE,
	parameter [15:0] T_MASS = `FPES_T_MASS
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata_r,
	output reg pready_r,
	output reg pslverr_r,
	output reg irq_r,
	output wire flash_prog_r,
	output wire flash_erase_r,
	output wire flash_mass_r,
	output wire flash_blank_r,
	output wire [15:0] flash_addr_r,
	output wire [7:0] flash_data_r
);
	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_ADDR = 2'b01;
	localparam [1:0] ST_CMD = 2'b10;
	localparam [1:0] ST_BUSY = 2'b11;

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [7:0] div_r;
	reg [7:0] cmd_r;
	reg [15:0] cap_addr_r;
	reg [7:0] cap_data_r;
	reg accerr_r;
	reg [1:0] intst_r;
	reg [1:0] intmsk_r;
	reg launch_r;
	reg err_ev;
	reg do_launch;
	reg do_capture;
	reg do_cmd;
	wire eng_busy;
	wire eng_done;
	wire setup;
	wire access;
	wire wr;
	wire rd;
	wire arr_sel;
	wire [15:0] arr_addr;
	wire mapped;
	wire [7:0] stat;

	function is_valid_cmd;
		input [7:0] c;
		begin
			is_valid_cmd = (c == `FPES_CMD_BLANK) || (c == `FPES_CMD_BYTE) || (c == `FPES_CMD_BURST) ||
				(c == `FPES_CMD_PAGE) || (c == `FPES_CMD_MASS);
		end
	endfunction

	function shadowed;
		input [15:0] a;
		begin
			shadowed = ((a >= `FPES_RAM_LO) && (a <= `FPES_RAM_HI)) ||
				((a >= `FPES_HPR_LO) && (a <= `FPES_HPR_HI));
		end
	endfunction

	assign setup = psel && !penable && !pready_r;
	assign access = psel && penable && pready_r;
	assign wr = access && pwrite;
	assign rd = access && !pwrite;
	assign arr_sel = (paddr[31:16] == `FPES_ARRAY_HI);
	assign arr_addr = paddr[15:0];
	assign mapped = arr_sel || (paddr == `FPES_OFS_CLKDIV) || (paddr == `FPES_OFS_CMD) ||
		(paddr == `FPES_OFS_STAT) || (paddr == `FPES_OFS_INTST) || (paddr == `FPES_OFS_INTMSK) ||
		(paddr == `FPES_OFS_CAPADDR) || (paddr == `FPES_OFS_CAPDATA);
	assign stat = {(state_r != ST_BUSY), (state_r != ST_BUSY), accerr_r, 5'b00000};

	// sequence checker: decides what each register write does to the pending command
	always @* begin
		state_nxt = state_r;
		err_ev = 1'b0;
		do_launch = 1'b0;
		do_capture = 1'b0;
		do_cmd = 1'b0;
		if (state_r == ST_BUSY) begin
			if (eng_done)
				state_nxt = ST_IDLE;
		end
		if (wr && arr_sel) begin
			// a pending error or an unset divider refuses the sequence outright
			if ((state_r == ST_IDLE) && !accerr_r && div_r[`FPES_DIV_LOADED] && !shadowed(arr_addr)) begin
				do_capture = 1'b1;
				state_nxt = ST_ADDR;
			end else if (state_r != ST_BUSY) begin
				err_ev = 1'b1;
				state_nxt = ST_IDLE;
			end else begin
				err_ev = 1'b1;
			end
		end else if (wr && (paddr == `FPES_OFS_CMD)) begin
			if ((state_r == ST_ADDR) && is_valid_cmd(pwdata[7:0])) begin
				do_cmd = 1'b1;
				state_nxt = ST_CMD;
			end else begin
				err_ev = 1'b1;
				if (state_r != ST_BUSY)
					state_nxt = ST_IDLE;
			end
		end else if (wr && (paddr == `FPES_OFS_STAT)) begin
			if (pwdata[`FPES_ST_CBEF]) begin
				if (state_r == ST_CMD) begin
					do_launch = 1'b1;
					state_nxt = ST_BUSY;
				end else if (state_r == ST_ADDR) begin
					err_ev = 1'b1;
					state_nxt = ST_IDLE;
				end
			end else if ((state_r == ST_ADDR) || (state_r == ST_CMD)) begin
				err_ev = 1'b1;
				state_nxt = ST_IDLE;
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
			cmd_r <= 8'h00;
			cap_addr_r <= 16'h0000;
			cap_data_r <= 8'h00;
			launch_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			launch_r <= do_launch;
			if (do_capture) begin
				cap_addr_r <= arr_addr;
				cap_data_r <= pwdata[7:0];
			end
			if (do_cmd)
				cmd_r <= pwdata[7:0];
		end
	end

	// access error: a new error in the clearing cycle wins
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			accerr_r <= 1'b0;
		end else if (err_ev) begin
			accerr_r <= 1'b1;
		end else if (wr && (paddr == `FPES_OFS_STAT) && pwdata[`FPES_ST_ACCERR]) begin
			accerr_r <= 1'b0;
		end
	end

	// divider: bit 7 records that software has set it up since reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= `FPES_RST_DIV;
		end else if (wr && (paddr == `FPES_OFS_CLKDIV) && (state_r != ST_BUSY) && !eng_busy) begin
			div_r <= {1'b1, pwdata[6:0]};
		end
	end

	// a read clears only the bits it reported, so an event at the setup edge is not lost
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			intst_r <= 2'b00;
			intmsk_r <= `FPES_RST_MASK;
			irq_r <= 1'b0;
		end else begin
			intst_r[`FPES_IRQ_DONE] <= eng_done || (intst_r[`FPES_IRQ_DONE] &&
				!(rd && (paddr == `FPES_OFS_INTST) && prdata_r[`FPES_IRQ_DONE]));
			intst_r[`FPES_IRQ_ERR] <= err_ev || (intst_r[`FPES_IRQ_ERR] &&
				!(rd && (paddr == `FPES_OFS_INTST) && prdata_r[`FPES_IRQ_ERR]));
			if (wr && (paddr == `FPES_OFS_INTMSK))
				intmsk_r <= pwdata[1:0];
			irq_r <= |(intst_r & intmsk_r);
		end
	end

	// apb: no wait states, read data captured at the end of setup
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else if (setup) begin
			pready_r <= 1'b1;
			pslverr_r <= !mapped;
			if (pwrite || arr_sel) begin
				prdata_r <= 32'h0000_0000;
			end else if (paddr == `FPES_OFS_CLKDIV) begin
				prdata_r <= {24'h00_0000, div_r};
			end else if (paddr == `FPES_OFS_CMD) begin
				prdata_r <= {24'h00_0000, cmd_r};
			end else if (paddr == `FPES_OFS_STAT) begin
				prdata_r <= {24'h00_0000, stat};
			end else if (paddr == `FPES_OFS_INTST) begin
				prdata_r <= {30'h0000_0000, intst_r};
			end else if (paddr == `FPES_OFS_INTMSK) begin
				prdata_r <= {30'h0000_0000, intmsk_r};
			end else if (paddr == `FPES_OFS_CAPADDR) begin
				prdata_r <= {16'h0000, cap_addr_r};
			end else if (paddr == `FPES_OFS_CAPDATA) begin
				prdata_r <= {24'h00_0000, cap_data_r};
			end else begin
				prdata_r <= 32'h0000_0000;
			end
		end else begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	fpes_engine #(
		.T_PAGE(T_PAGE),
		.T_MASS(T_MASS)
	) u_engine (
		.pclk(pclk),
		.presetn(presetn),
		.start(launch_r),
		.cmd(cmd_r),
		.addr(cap_addr_r),
		.data(cap_data_r),
		.div(div_r),
		.busy_r(eng_busy),
		.done_r(eng_done),
		.flash_prog_r(flash_prog_r),
		.flash_erase_r(flash_erase_r),
		.flash_mass_r(flash_mass_r),
		.flash_blank_r(flash_blank_r),
		.flash_addr_r(flash_addr_r),
		.flash_data_r(flash_data_r)
	);
endmodule // fpes_sequencer

/* sim/fpes_sequencer_props.sv */
`timescale 1ns/1ps
`include "fpes_map.vh"
module fpes_seq_props #(
	parameter [15:0] T_PAGE = 16'h0008,
	parameter [15:0] T_MASS = 16'h000C
) (
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [31:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata_r,
	input logic pready_r,
	input logic pslverr_r,
	input logic irq_r,
	input logic flash_prog_r,
	input logic flash_erase_r,
	input logic flash_mass_r,
	input logic flash_blank_r,
	input logic [15:0] flash_addr_r,
	input logic [7:0] flash_data_r
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire op = flash_prog_r | flash_erase_r | flash_blank_r;
	wire setup = psel && !penable;
	// saturates, so an old launch never excuses a late start
	logic [3:0] since_go_r;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			since_go_r <= 4'hF;
		else if (psel && penable && pready_r && pwrite && paddr == `FPES_OFS_STAT && pwdata[7])
			since_go_r <= 4'h0;
		else if (since_go_r != 4'hF)
			since_go_r <= since_go_r + 4'h1;
	end
	property p_ready; setup |=> pready_r ##1 !pready_r; endproperty
	a_ready: assert property (p_ready) else $error("ready not one cycle after setup");
	property p_unmap; setup && paddr == 32'h0000_001C |=> pslverr_r && prdata_r == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
	property p_arr; setup && !pwrite && paddr[31:16] == `FPES_ARRAY_HI |=> !pslverr_r; endproperty
	a_arr: assert property (p_arr) else $error("array read refused");
	property p_page; flash_erase_r && !flash_mass_r |-> flash_addr_r[8:0] == 9'h000; endproperty
	a_page: assert property (p_page) else $error("page erase not page aligned");
	property p_nodata; flash_erase_r || flash_blank_r |-> flash_data_r == 8'h00; endproperty
	a_nodata: assert property (p_nodata) else $error("erase carries data");
	property p_one; op |-> $onehot({flash_prog_r, flash_erase_r, flash_blank_r}) && (!flash_mass_r || flash_erase_r);
	endproperty
	a_one: assert property (p_one) else $error("operation kinds overlap");
	property p_go; $rose(op) |-> since_go_r <= 4'h5; endproperty
	a_go: assert property (p_go) else $error("operation without launch");
	property p_hold; op && $past(op) |-> $stable(flash_addr_r) && $stable(flash_data_r); endproperty
	a_hold: assert property (p_hold) else $error("operand changed mid operation");
	property p_errrdy; pslverr_r |-> pready_r; endproperty
	a_errrdy: assert property (p_errrdy) else $error("error without ready");
	c_prog: cover property ($rose(flash_prog_r));
	c_mass: cover property ($rose(flash_mass_r));
	c_blank: cover property ($rose(flash_blank_r));
	c_err: cover property (pslverr_r);
endmodule // fpes_seq_props
bind fpes_sequencer fpes_seq_props #(.T_PAGE(T_PAGE), .T_MASS(T_MASS)) u_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
	.irq_r(irq_r), .flash_prog_r(flash_prog_r), .flash_erase_r(flash_erase_r), .flash_mass_r(flash_mass_r),
	.flash_blank_r(flash_blank_r), .flash_addr_r(flash_addr_r), .flash_data_r(flash_data_r)
);

/* sim/tb_flash_program_erase_sequencer.sv */
`timescale 1ns/1ps
`include "fpes_map.vh"
module tb_flash_program_erase_sequencer;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, op_q = 1'b0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0;
	wire [31:0] prdata_r;
	wire pready_r, pslverr_r, irq_r, fp, fe, fm, fb;
	wire [15:0] fa;
	wire [7:0] fd;
	logic [32:0] rq[$], oq[$];
	integer errors = 0, cmp_count = 0, i;
	logic [7:0] c, dt;
	logic [15:0] a;
	logic [7:0] cmds [0:4] = '{`FPES_CMD_BLANK, `FPES_CMD_BYTE, `FPES_CMD_BURST, `FPES_CMD_PAGE, `FPES_CMD_MASS};
	fpes_sequencer #(.T_PAGE(16'h0008), .T_MASS(16'h000C)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r), .irq_r(irq_r),
		.flash_prog_r(fp), .flash_erase_r(fe), .flash_mass_r(fm), .flash_blank_r(fb),
		.flash_addr_r(fa), .flash_data_r(fd)
	);
	initial forever #2.5 pclk = ~pclk;
	task chk(input logic [32:0] got, input logic [32:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task end_sim;
		$display("errors=%0d compares=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task apb(input logic w, input logic [31:0] ad, input logic [31:0] d, input logic [32:0] e);
		integer n;
		if (!w)
			rq.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready_r !== 1'b1 && n < 40);
		if (n >= 40) begin
			errors++;
			end_sim;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		// idle cycle: the next request never reassigns in the same step
		@(posedge pclk);
	endtask
	task wr(input logic [31:0] ad, input logic [31:0] d);
		apb(1'b1, ad, d, 33'h0);
	endtask
	task rd(input logic [31:0] ad, input logic [32:0] e);
		apb(1'b0, ad, 32'h0, e);
	endtask
	function logic [31:0] arr(input logic [15:0] x);
		return {`FPES_ARRAY_HI, x};
	endfunction
	task wait_irq;
		integer n;
		for (n = 0; n < 200 && irq_r !== 1'b1; n++)
			@(posedge pclk);
		if (n >= 200) begin
			errors++;
			end_sim;
		end
	endtask
	// one faulty write, then error seen, event read-cleared, flag cleared
	task bad(input logic [31:0] ad, input logic [31:0] d, input logic ie);
		wr(ad, d);
		rd(`FPES_OFS_STAT, 33'h0E0);
		chk({32'h0, irq_r}, {32'h0, ie});
		rd(`FPES_OFS_INTST, 33'h002);
		wr(`FPES_OFS_STAT, 32'h20);
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready_r === 1'b1 && !pwrite)
			chk({pslverr_r, prdata_r}, rq.pop_front());
		if ((fp | fe | fb) === 1'b1 && !op_q)
			chk({fp, fe, fm, fb, fa, fd}, oq.pop_front());
		op_q <= fp | fe | fb;
	end
	initial begin
		void'($urandom(14));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`FPES_OFS_STAT, 33'h0C0);
		rd(`FPES_OFS_CLKDIV, 33'h0);
		rd(32'h0000_001C, {1'b1, 32'h0});
		bad(arr(16'h2000), 32'h5A, 1'b0);
		wr(`FPES_OFS_CLKDIV, 32'h0);
		rd(`FPES_OFS_CLKDIV, 33'h080);
		wr(`FPES_OFS_INTMSK, 32'h3);
		bad(`FPES_OFS_CMD, 32'h20, 1'b1);
		wr(arr(16'h3000), 32'h11);
		bad(`FPES_OFS_STAT, 32'h0, 1'b1);
		wr(arr(16'h3000), 32'h11);
		bad(`FPES_OFS_CMD, 32'h33, 1'b1);
		wr(arr(16'h3000), 32'h11);
		bad(`FPES_OFS_STAT, 32'h80, 1'b1);
		bad(arr(16'h0100), 32'h11, 1'b1);
		for (i = 0; i < 5; i++) begin
			c = cmds[i];
			a = 16'($urandom_range(65535, 8192));
			dt = 8'($urandom);
			oq.push_back({!c[6] && c != `FPES_CMD_BLANK, c[6], c == `FPES_CMD_MASS, c == `FPES_CMD_BLANK,
				c == `FPES_CMD_PAGE ? a & 16'hFE00 : a, (c[6] || c == `FPES_CMD_BLANK) ? 8'h00 : dt});
			wr(arr(a), {24'h0, dt});
			wr(`FPES_OFS_CMD, {24'h0, c});
			rd(`FPES_OFS_CMD, {25'h0, c});
			wr(`FPES_OFS_STAT, 32'h80);
			rd(`FPES_OFS_STAT, 33'h000);
			wait_irq;
			rd(`FPES_OFS_INTST, 33'h001);
			rd(`FPES_OFS_STAT, 33'h0C0);
			rd(`FPES_OFS_CAPADDR, {17'h0, a});
		end
		// mid-run reset: the divider has to be set up again before any command
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`FPES_OFS_CLKDIV, 33'h0);
		bad(arr(16'h2000), 32'h5A, 1'b0);
		end_sim;
	end
endmodule // tb_flash_program_erase_sequencer
